// *** core/pbcs_pkg.sv ***
/*
 * pbcs_pkg: constants, carrier structs and state types for the basic control and status register pair.
 * assumes a single 20 MHz core clock and a clause 22 management master outside.
 */
package pbcs_pkg;

   // register addresses on the management interface
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STAT = 5'h01;

   // control field positions
   localparam int CTRL_RESET_BIT = 15;
   localparam int CTRL_LOOP_BIT = 14;
   localparam int CTRL_SPD_LSB_BIT = 13;
   localparam int CTRL_AUTONEG_ENABLE_BIT_BIT = 12;
   localparam int CTRL_PDOWN_BIT = 11;
   localparam int CTRL_ISO_BIT = 10;
   localparam int CTRL_AN_RESTART_BIT = 9;
   localparam int CTRL_DUPLEX_BIT = 8;
   localparam int CTRL_COLL_BIT = 7;
   localparam int CTRL_SPD_MSB_BIT = 6;
   localparam logic [15:0] CTRL_RESET_VAL = 16'h1140;
   localparam logic [15:0] CTRL_RW_MASK = 16'h7DC0;

   // status field positions and constant ability bits
   localparam int STAT_AN_DONE_BIT = 5;
   localparam int STAT_RFAULT_BIT = 4;
   localparam int STAT_LINK_BIT = 2;
   localparam int STAT_JABBER_BIT = 1;
   localparam logic [15:0] STAT_FIXED_VAL = 16'h7949;

   // management frame fields
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [4:0] HDR_LAST = 5'h0B;
   localparam logic [4:0] TA_LAST = 5'h01;
   localparam logic [4:0] DATA_LAST = 5'h0F;
   localparam logic [4:0] DATA_BITS = 5'h10;
   localparam logic [4:0] SKIP_LAST = 5'h11;

   // speed codes {msb, lsb}
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_RESERVED = 2'h3;

   // soft reset hold time
   localparam int CLK_PERIOD_NS = 50;
   localparam int SOFT_RST_NS = 1000;
   localparam logic [7:0] SOFT_RST_CYCLES = 8'((SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {MS_IDLE, MS_START, MS_HDR, MS_WTA, MS_WDATA, MS_RTA, MS_RDATA, MS_SKIP} pbcs_mdio_st_type;

   typedef struct packed {
      logic an_complete;
      logic link_up;
      logic remote_fault;
      logic jabber;
      logic [1:0] an_speed;
      logic an_full_duplex;
   } pbcs_core_status_type;

   typedef struct packed {
      logic core_reset;
      logic loopback_en;
      logic an_enable;
      logic an_restart;
      logic power_down;
      logic isolate;
      logic collision_test;
      logic [1:0] speed;
      logic full_duplex;
   } pbcs_core_ctrl_type;

   typedef struct packed {
      logic mdc_s1;
      logic mdc_s2;
      logic mdc_d;
      logic mdio_s1;
      logic mdio_s2;
      pbcs_mdio_st_type st;
      logic [4:0] bitcnt;
      logic [11:0] hdr;
      logic [4:0] reg_addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic mdio_out;
      logic mdio_oe;
      logic [15:0] ctrl;
      logic [7:0] rst_cnt;
      logic an_restart;
      logic rf_latch;
      logic jab_latch;
      logic link_low_seen;
   } pbcs_state_type;

endpackage : pbcs_pkg

// *** core/pbcs_regs.sv ***
/*
 * pbcs_regs: management frame slave holding the basic control and status registers.
 * assumes mdc and mdio_in arrive from pins (synchronised here) and core status comes from the core clock.
 */
// Summary of operation
// - writing one to control bit 15 resets the core; bit clears when done
// - control bit 14 enables loopback; the loopback kind is chosen elsewhere
// - bits 13 low and 6 high select speed: 10 gigabit, 01 hundred, 00 ten
// - manual speed bits are ignored while auto-negotiation is enabled
// - bit 12 resets to one; cleared means manual speed and duplex apply
// - bit 11 powers the core down; resets to zero
// - bit 10 isolates the core from its data interface
// - writing one to bit 9 restarts auto-negotiation, bit clears itself
// - bit 8 selects full duplex when one; resets to one; manual mode only
// - bit 7 enables the collision test
// - control bits 5 to 0 always read zero
// - status bit 15 always reads zero
// - status bits 14 to 11 always read one
// - status bits 10 and 9 always read zero
// - status bit 8 reads one: extended status exists
// - status bit 7 always reads zero
// - status bit 6 reads one; frames without preamble are accepted
// - status bit 5 shows auto-negotiation complete
// - status bit 4 latches remote fault until status read or reset
// - status bit 3 reads one: auto-negotiation ability
// - status bit 2 shows link, held low after failure until status read
// - status bit 1 latches jabber detection
// - status bit 0 reads one: extended registers exist
`timescale 1ns/1ns
module pbcs_regs #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire pbcs_pkg::pbcs_core_status_type core_stat,
   output pbcs_pkg::pbcs_core_ctrl_type core_ctrl
);

   pbcs_pkg::pbcs_state_type s_reg;
   pbcs_pkg::pbcs_state_type s_next;
   logic rise;
   logic stat_read;
   logic [15:0] stat_val;
   logic [15:0] ctrl_val;
   logic [11:0] hdr_new;
   logic [15:0] w_new;
   logic ctrl_wr;
   logic rst_wr;

   // status word assembly
   always_comb begin
      stat_val = pbcs_pkg::STAT_FIXED_VAL;
      stat_val[pbcs_pkg::STAT_AN_DONE_BIT] = core_stat.an_complete;
      stat_val[pbcs_pkg::STAT_RFAULT_BIT] = s_reg.rf_latch;
      stat_val[pbcs_pkg::STAT_LINK_BIT] = core_stat.link_up & ~s_reg.link_low_seen;
      stat_val[pbcs_pkg::STAT_JABBER_BIT] = s_reg.jab_latch;
      ctrl_val = s_reg.ctrl & pbcs_pkg::CTRL_RW_MASK;
      ctrl_val[pbcs_pkg::CTRL_RESET_BIT] = (s_reg.rst_cnt != 8'h00);
   end

   always_comb begin
      s_next = s_reg;
      s_next.mdc_s1 = mdc;
      s_next.mdc_s2 = s_reg.mdc_s1;
      s_next.mdc_d = s_reg.mdc_s2;
      s_next.mdio_s1 = mdio_in;
      s_next.mdio_s2 = s_reg.mdio_s1;
      s_next.an_restart = 1'b0;
      rise = s_reg.mdc_s2 & ~s_reg.mdc_d;
      stat_read = 1'b0;
      hdr_new = {s_reg.hdr[10:0], s_reg.mdio_s2};
      w_new = {s_reg.wdata[14:0], s_reg.mdio_s2};
      if (s_reg.rst_cnt != 8'h00) begin
         s_next.rst_cnt = s_reg.rst_cnt - 8'h01;
      end
      if (rise) begin
         case (s_reg.st)
            pbcs_pkg::MS_IDLE: begin
               // a zero after idle is the first start bit, preamble optional
               if (!s_reg.mdio_s2) begin
                  s_next.st = pbcs_pkg::MS_START;
               end
            end
            pbcs_pkg::MS_START: begin
               s_next.bitcnt = 5'h00;
               s_next.st = s_reg.mdio_s2 ? pbcs_pkg::MS_HDR : pbcs_pkg::MS_IDLE;
            end
            pbcs_pkg::MS_HDR: begin
               s_next.hdr = hdr_new;
               s_next.bitcnt = s_reg.bitcnt + 5'h01;
               if (s_reg.bitcnt == pbcs_pkg::HDR_LAST) begin
                  s_next.bitcnt = 5'h00;
                  s_next.reg_addr = hdr_new[4:0];
                  s_next.st = pbcs_pkg::MS_SKIP;
                  if (hdr_new[9:5] == PHY_ADDR && hdr_new[4:1] == 4'h0) begin
                     if (hdr_new[11:10] == pbcs_pkg::OP_READ) begin
                        s_next.st = pbcs_pkg::MS_RTA;
                     end else if (hdr_new[11:10] == pbcs_pkg::OP_WRITE) begin
                        s_next.st = pbcs_pkg::MS_WTA;
                     end
                  end
               end
            end
            pbcs_pkg::MS_WTA: begin
               s_next.bitcnt = s_reg.bitcnt + 5'h01;
               if (s_reg.bitcnt == pbcs_pkg::TA_LAST) begin
                  s_next.bitcnt = 5'h00;
                  s_next.st = pbcs_pkg::MS_WDATA;
               end
            end
            pbcs_pkg::MS_WDATA: begin
               s_next.wdata = w_new;
               s_next.bitcnt = s_reg.bitcnt + 5'h01;
               if (s_reg.bitcnt == pbcs_pkg::DATA_LAST) begin
                  s_next.st = pbcs_pkg::MS_IDLE;
                  if (s_reg.reg_addr == pbcs_pkg::REG_CTRL) begin
                     if (w_new[pbcs_pkg::CTRL_RESET_BIT]) begin
                        s_next.rst_cnt = pbcs_pkg::SOFT_RST_CYCLES;
                     end else begin
                        s_next.ctrl = w_new & pbcs_pkg::CTRL_RW_MASK;
                        s_next.an_restart = w_new[pbcs_pkg::CTRL_AN_RESTART_BIT];
                     end
                  end
               end
            end
            pbcs_pkg::MS_RTA: begin
               // drive the second turnaround bit low, snapshot the word
               s_next.mdio_oe = 1'b1;
               s_next.mdio_out = 1'b0;
               s_next.bitcnt = 5'h00;
               s_next.st = pbcs_pkg::MS_RDATA;
               if (s_reg.reg_addr == pbcs_pkg::REG_STAT) begin
                  s_next.rdata = stat_val;
                  stat_read = 1'b1;
               end else begin
                  s_next.rdata = ctrl_val;
               end
            end
            pbcs_pkg::MS_RDATA: begin
               if (s_reg.bitcnt == pbcs_pkg::DATA_BITS) begin
                  s_next.mdio_oe = 1'b0;
                  s_next.st = pbcs_pkg::MS_IDLE;
               end else begin
                  s_next.mdio_out = s_reg.rdata[15];
                  s_next.rdata = {s_reg.rdata[14:0], 1'b0};
                  s_next.bitcnt = s_reg.bitcnt + 5'h01;
               end
            end
            pbcs_pkg::MS_SKIP: begin
               s_next.bitcnt = s_reg.bitcnt + 5'h01;
               if (s_reg.bitcnt == pbcs_pkg::SKIP_LAST) begin
                  s_next.st = pbcs_pkg::MS_IDLE;
               end
            end
            default: begin
               s_next.st = pbcs_pkg::MS_IDLE;
               s_next.mdio_oe = 1'b0;
            end
         endcase
      end
      // latched bits: read clears, a new event in the same cycle wins
      if (stat_read) begin
         s_next.rf_latch = 1'b0;
         s_next.jab_latch = 1'b0;
         s_next.link_low_seen = 1'b0;
      end
      if (core_stat.remote_fault) begin
         s_next.rf_latch = 1'b1;
      end
      if (core_stat.jabber) begin
         s_next.jab_latch = 1'b1;
      end
      if (!core_stat.link_up) begin
         s_next.link_low_seen = 1'b1;
      end
      // soft reset restores control defaults and clears the high latches
      if (s_next.rst_cnt != 8'h00) begin
         s_next.ctrl = pbcs_pkg::CTRL_RESET_VAL;
         s_next.rf_latch = 1'b0;
         s_next.jab_latch = 1'b0;
         s_next.an_restart = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.ctrl <= pbcs_pkg::CTRL_RESET_VAL;
      end else begin
         s_reg <= s_next;
      end
   end

   // control outputs to the core
   always_comb begin
      core_ctrl.core_reset = (s_reg.rst_cnt != 8'h00);
      core_ctrl.loopback_en = s_reg.ctrl[pbcs_pkg::CTRL_LOOP_BIT];
      core_ctrl.an_enable = s_reg.ctrl[pbcs_pkg::CTRL_AUTONEG_ENABLE_BIT_BIT];
      core_ctrl.an_restart = s_reg.an_restart;
      core_ctrl.power_down = s_reg.ctrl[pbcs_pkg::CTRL_PDOWN_BIT];
      core_ctrl.isolate = s_reg.ctrl[pbcs_pkg::CTRL_ISO_BIT];
      core_ctrl.collision_test = s_reg.ctrl[pbcs_pkg::CTRL_COLL_BIT];
      if (s_reg.ctrl[pbcs_pkg::CTRL_AUTONEG_ENABLE_BIT_BIT]) begin
         core_ctrl.speed = core_stat.an_speed;
         core_ctrl.full_duplex = core_stat.an_full_duplex;
      end else begin
         core_ctrl.speed = {s_reg.ctrl[pbcs_pkg::CTRL_SPD_MSB_BIT], s_reg.ctrl[pbcs_pkg::CTRL_SPD_LSB_BIT]};
         if (core_ctrl.speed == pbcs_pkg::SPD_RESERVED) begin
            core_ctrl.speed = pbcs_pkg::SPD_10;
         end
         core_ctrl.full_duplex = s_reg.ctrl[pbcs_pkg::CTRL_DUPLEX_BIT];
      end
   end

   assign mdio_out = s_reg.mdio_out;
   assign mdio_oe = s_reg.mdio_oe;

   // last data bit of a control write, split by the soft reset bit
   assign ctrl_wr = rise && s_reg.st == pbcs_pkg::MS_WDATA && s_reg.bitcnt == pbcs_pkg::DATA_LAST
      && s_reg.reg_addr == pbcs_pkg::REG_CTRL && !w_new[pbcs_pkg::CTRL_RESET_BIT] && s_next.rst_cnt == 8'h00;
   assign rst_wr = rise && s_reg.st == pbcs_pkg::MS_WDATA && s_reg.bitcnt == pbcs_pkg::DATA_LAST
      && s_reg.reg_addr == pbcs_pkg::REG_CTRL && w_new[pbcs_pkg::CTRL_RESET_BIT];

   localparam int RST_SPAN = 20;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   chk_rst_self_clear: assert property ($rose(core_ctrl.core_reset) |-> ##RST_SPAN !core_ctrl.core_reset)
      else $error("soft reset did not clear after its hold time");
   chk_speed_auto: assert property (core_ctrl.an_enable |-> core_ctrl.speed == core_stat.an_speed)
      else $error("manual speed leaked while auto-negotiation enabled");
   chk_speed_manual: assert property (!core_ctrl.an_enable && s_reg.ctrl[6] == 1'b0
      |-> core_ctrl.speed[0] == s_reg.ctrl[13] && core_ctrl.full_duplex == s_reg.ctrl[8])
      else $error("manual speed or duplex not applied");
   chk_restart_pulse: assert property (core_ctrl.an_restart |=> !core_ctrl.an_restart)
      else $error("restart pulse longer than one cycle");
   chk_rf_set: assert property (core_stat.remote_fault && s_next.rst_cnt == 8'h00 |=> s_reg.rf_latch)
      else $error("remote fault not latched");
   chk_rf_hold: assert property (s_reg.rf_latch && !stat_read && s_next.rst_cnt == 8'h00 |=> s_reg.rf_latch)
      else $error("remote fault latch dropped without a read");
   chk_link_low: assert property (!core_stat.link_up ##1 !stat_read |=> stat_val[2] == 1'b0)
      else $error("link status not held low after failure");
   chk_jab_set: assert property (core_stat.jabber && s_next.rst_cnt == 8'h00 |=> s_reg.jab_latch)
      else $error("jabber not latched");
   chk_read_drive: assert property (rise && s_reg.st == pbcs_pkg::MS_RTA |=> mdio_oe && !mdio_out)
      else $error("turnaround zero not driven");
   chk_ctrl_reserved: assert property (ctrl_val[5:0] == 6'h00 && stat_val[7] == 1'b0)
      else $error("reserved bits read nonzero");

   // control writes reach the core; the duplex bit is checked in the register
   chk_loop_write: assert property (ctrl_wr
      |=> core_ctrl.loopback_en == $past(w_new[pbcs_pkg::CTRL_LOOP_BIT]))
      else $error("loopback enable not taken from write");
   chk_autoneg_enable_bit_write: assert property (ctrl_wr
      |=> core_ctrl.an_enable == $past(w_new[pbcs_pkg::CTRL_AUTONEG_ENABLE_BIT_BIT]))
      else $error("auto-negotiation enable not taken from write");
   chk_pdown_write: assert property (ctrl_wr
      |=> core_ctrl.power_down == $past(w_new[pbcs_pkg::CTRL_PDOWN_BIT]))
      else $error("power down not taken from write");
   chk_iso_write: assert property (ctrl_wr
      |=> core_ctrl.isolate == $past(w_new[pbcs_pkg::CTRL_ISO_BIT]))
      else $error("isolate not taken from write");
   chk_coll_write: assert property (ctrl_wr
      |=> core_ctrl.collision_test == $past(w_new[pbcs_pkg::CTRL_COLL_BIT]))
      else $error("collision test not taken from write");
   chk_duplex_write: assert property (ctrl_wr
      |=> s_reg.ctrl[pbcs_pkg::CTRL_DUPLEX_BIT] == $past(w_new[pbcs_pkg::CTRL_DUPLEX_BIT]))
      else $error("duplex bit not taken from write");

   // restart pulse only from a control write
   chk_restart_write: assert property (ctrl_wr && w_new[pbcs_pkg::CTRL_AN_RESTART_BIT]
      |=> core_ctrl.an_restart)
      else $error("restart write gave no pulse");
   chk_restart_only: assert property (!ctrl_wr
      |=> !core_ctrl.an_restart)
      else $error("restart pulse without a write");
   chk_restart_reads_zero: assert property (!ctrl_val[pbcs_pkg::CTRL_AN_RESTART_BIT])
      else $error("restart bit reads one");

   // speed and duplex selection
   chk_duplex_auto: assert property (core_ctrl.an_enable
      |-> core_ctrl.full_duplex == core_stat.an_full_duplex)
      else $error("manual duplex leaked while auto-negotiation enabled");
   chk_speed_giga: assert property (!core_ctrl.an_enable && s_reg.ctrl[6] && !s_reg.ctrl[13]
      |-> core_ctrl.speed == 2'h2)
      else $error("manual gigabit speed not applied");
   chk_speed_reserved: assert property (!core_ctrl.an_enable && s_reg.ctrl[6] && s_reg.ctrl[13]
      |-> core_ctrl.speed == pbcs_pkg::SPD_10)
      else $error("reserved speed code not mapped");

   // soft reset
   chk_rst_start: assert property (rst_wr
      |=> core_ctrl.core_reset)
      else $error("soft reset write did not start reset");
   chk_rst_defaults: assert property (core_ctrl.core_reset
      |-> s_reg.ctrl == pbcs_pkg::CTRL_RESET_VAL)
      else $error("control defaults not held during soft reset");
   chk_rst_clears: assert property (core_ctrl.core_reset
      |-> !s_reg.rf_latch && !s_reg.jab_latch)
      else $error("latched faults survive soft reset");
   chk_rst_readback: assert property (ctrl_val[pbcs_pkg::CTRL_RESET_BIT] == core_ctrl.core_reset)
      else $error("reset bit readback wrong");
   chk_rst_pdown: assert property (core_ctrl.core_reset |-> !core_ctrl.power_down)
      else $error("power down set during soft reset");
   chk_rst_loop: assert property (core_ctrl.core_reset |-> !core_ctrl.loopback_en)
      else $error("loopback set during soft reset");
   chk_rst_iso: assert property (core_ctrl.core_reset |-> !core_ctrl.isolate)
      else $error("isolate set during soft reset");
   chk_rst_coll: assert property (core_ctrl.core_reset |-> !core_ctrl.collision_test)
      else $error("collision test set during soft reset");
   chk_rst_autoneg_enable_bit: assert property (core_ctrl.core_reset |-> core_ctrl.an_enable)
      else $error("auto-negotiation disabled during soft reset");

   // constant status bits and the completion bit
   chk_t4_zero: assert property (!stat_val[15])
      else $error("status bit 15 reads one");
   chk_tx_abilities: assert property (stat_val[14:11] == 4'hF)
      else $error("ability bits not all one");
   chk_t2_zero: assert property (stat_val[10:9] == 2'h0)
      else $error("status bits 10 and 9 not zero");
   chk_ext_status: assert property (stat_val[8])
      else $error("extended status bit not one");
   chk_preamble_flag: assert property (stat_val[6])
      else $error("preamble suppression bit not one");
   chk_an_ability: assert property (stat_val[3])
      else $error("auto-negotiation ability bit not one");
   chk_ext_cap: assert property (stat_val[0])
      else $error("extended capability bit not one");
   chk_an_done: assert property (stat_val[pbcs_pkg::STAT_AN_DONE_BIT] == core_stat.an_complete)
      else $error("completion bit does not follow the core");

   // latched status bits
   chk_jab_hold: assert property (s_reg.jab_latch && !stat_read && s_next.rst_cnt == 8'h00
      |=> s_reg.jab_latch)
      else $error("jabber latch dropped without a read");
   chk_jab_clear: assert property (stat_read && !core_stat.jabber && s_next.rst_cnt == 8'h00
      |=> !s_reg.jab_latch)
      else $error("jabber latch not cleared by read");
   chk_rf_clear: assert property (stat_read && !core_stat.remote_fault
      |=> !s_reg.rf_latch)
      else $error("remote fault latch not cleared by read");
   chk_link_clear: assert property (stat_read && core_stat.link_up
      |=> !s_reg.link_low_seen)
      else $error("link low latch not cleared by read");
   chk_link_live: assert property (stat_val[pbcs_pkg::STAT_LINK_BIT] |-> core_stat.link_up)
      else $error("link reported up while down");

   // read frames
   chk_stat_snapshot: assert property (rise && s_reg.st == pbcs_pkg::MS_RTA && s_reg.reg_addr == pbcs_pkg::REG_STAT
      |=> s_reg.rdata == $past(stat_val))
      else $error("status word not captured at turnaround");
   chk_ctrl_snapshot: assert property (rise && s_reg.st == pbcs_pkg::MS_RTA && s_reg.reg_addr == pbcs_pkg::REG_CTRL
      |=> s_reg.rdata == $past(ctrl_val))
      else $error("control word not captured at turnaround");
   chk_read_bits: assert property (rise && s_reg.st == pbcs_pkg::MS_RDATA && s_reg.bitcnt != pbcs_pkg::DATA_BITS
      |=> mdio_out == $past(s_reg.rdata[15]))
      else $error("read bit not shifted out");
   chk_read_release: assert property (rise && s_reg.st == pbcs_pkg::MS_RDATA && s_reg.bitcnt == pbcs_pkg::DATA_BITS
      |=> !mdio_oe)
      else $error("data line not released after read");
   chk_oe_only_read: assert property (mdio_oe |-> s_reg.st == pbcs_pkg::MS_RDATA)
      else $error("data line driven outside a read");
   chk_start_bit: assert property (rise && s_reg.st == pbcs_pkg::MS_IDLE && !s_reg.mdio_s2
      |=> s_reg.st == pbcs_pkg::MS_START)
      else $error("start bit without preamble not taken");
   chk_bad_start: assert property (rise && s_reg.st == pbcs_pkg::MS_START && !s_reg.mdio_s2
      |=> s_reg.st == pbcs_pkg::MS_IDLE)
      else $error("bad second start bit not refused");

endmodule : pbcs_regs

// *** bench/pbcs_mdio_host.sv ***
/*
 * pbcs_mdio_host: behavioural management master that makes mdc and frames on the mdio line.
 * assumes the bench resolves the line with a pull-up; mdc stands low outside frames.
 */
`timescale 1ns/1ns
module pbcs_mdio_host (
   output logic mdc,
   output logic drv_en,
   output logic drv_val,
   input wire logic line
);
   initial begin
      mdc = 1'h0;
      drv_en = 1'h0;
      drv_val = 1'h1;
   end
   // pre leading ones, then st, op, phy, reg, ta, data; read data sampled on rising mdc
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
         input logic [15:0] wd, input int pre, output logic [15:0] rd);
      logic [63:0] f;
      int i;
      f = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
      rd = 16'h0000;
      for (i = pre + 31; i >= 0; i--) begin
         drv_en = (i > 17) || (op == pbcs_pkg::OP_WRITE);
         drv_val = f[i];
         #200 mdc = 1'h1;
         if (i < 16) rd[i] = line;
         #200 mdc = 1'h0;
      end
      drv_en = 1'h0;
   endtask : xfer
endmodule : pbcs_mdio_host

// *** bench/tb_pbcs_regs.sv ***
/*
 * tb_pbcs_regs: register tests through management frames.
 * assumes pbcs_regs and pbcs_mdio_host; mdio has a pull-up.
 */
`timescale 1ns/1ns
module tb_pbcs_regs;
   logic clk, rstn, mdc, drv_en, drv_val, mdio_out, mdio_oe, line, oe_seen;
   pbcs_pkg::pbcs_core_status_type core_stat;
   pbcs_pkg::pbcs_core_ctrl_type core_ctrl;
   int fails = 0, n_compared = 0, cyc = 0, n_rst = 0, n_rs = 0;
   logic [15:0] rd;
   logic [15:0] wv [7] = '{16'h0040, 16'h2000, 16'h0100, 16'h0000, 16'h4C80, 16'h2040, 16'h3DFF};
   assign line = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'h1);
   pbcs_regs pbcs_regs_i (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_in(line), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .core_stat(core_stat), .core_ctrl(core_ctrl));
   pbcs_mdio_host pbcs_mdio_host_i (.mdc(mdc), .drv_en(drv_en), .drv_val(drv_val), .line(line));
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (core_ctrl.core_reset === 1'h1) n_rst <= n_rst + 1;
      if (core_ctrl.an_restart === 1'h1) n_rs <= n_rs + 1;
      if (mdio_oe !== 1'h0) oe_seen <= 1'h1;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd_reg(input logic [4:0] ra, input int pre, output logic [15:0] v);
      pbcs_mdio_host_i.xfer(pbcs_pkg::OP_READ, 5'h01, ra, 16'h0000, pre, v);
   endtask : rd_reg
   task automatic wr_reg(input logic [4:0] ra, input logic [15:0] v);
      logic [15:0] d;
      pbcs_mdio_host_i.xfer(pbcs_pkg::OP_WRITE, 5'h01, ra, v, 1, d);
      repeat (8) @(posedge clk);
   endtask : wr_reg
   task automatic set_stat(input logic [6:0] v);
      @(posedge clk);
      #1 core_stat = v;
   endtask : set_stat
   function automatic pbcs_pkg::pbcs_core_ctrl_type exp_ctrl(input logic [15:0] w);
      logic [1:0] s;
      s = {w[6], w[13]};
      s = w[12] ? core_stat.an_speed : ((s == 2'h3) ? 2'h0 : s);
      return '{1'h0, w[14], w[12], 1'h0, w[11], w[10], w[7], s, w[12] ? core_stat.an_full_duplex : w[8]};
   endfunction : exp_ctrl
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   initial begin
      rstn = 1'h0;
      core_stat = '0;
      oe_seen = 1'h0;
      repeat (12) @(posedge clk);
      #1 rstn = 1'h1;
      repeat (6) @(posedge clk);
      rd_reg(pbcs_pkg::REG_CTRL, 32, rd);
      chk(rd, 16'h1140);
      chk({6'h0, core_ctrl}, {6'h0, exp_ctrl(16'h1140)});
      rd_reg(pbcs_pkg::REG_STAT, 32, rd);
      chk(rd, 16'h7949);
      $display("test reset values done");
      set_stat(7'h60);
      rd_reg(pbcs_pkg::REG_STAT, 1, rd);
      chk(rd, 16'h7969);
      rd_reg(pbcs_pkg::REG_STAT, 1, rd);
      chk(rd, 16'h796D);
      set_stat(7'h40);
      set_stat(7'h78);
      set_stat(7'h60);
      rd_reg(pbcs_pkg::REG_STAT, 1, rd);
      chk(rd, 16'h797B);
      rd_reg(pbcs_pkg::REG_STAT, 1, rd);
      chk(rd, 16'h796D);
      $display("test status latches done");
      set_stat(7'h62);
      foreach (wv[k]) begin
         wr_reg(pbcs_pkg::REG_CTRL, wv[k]);
         chk({6'h0, core_ctrl}, {6'h0, exp_ctrl(wv[k])});
         rd_reg(pbcs_pkg::REG_CTRL, 1, rd);
         chk(rd, wv[k] & pbcs_pkg::CTRL_RW_MASK);
      end
      $display("test control fields done");
      n_rs = 0;
      wr_reg(pbcs_pkg::REG_CTRL, 16'h1200);
      chk(16'(n_rs), 16'h0001);
      rd_reg(pbcs_pkg::REG_CTRL, 1, rd);
      chk(rd, 16'h1000);
      $display("test restart done");
      oe_seen = 1'h0;
      pbcs_mdio_host_i.xfer(pbcs_pkg::OP_READ, 5'h02, pbcs_pkg::REG_CTRL, 16'h0000, 1, rd);
      chk(rd, 16'hFFFF);
      rd_reg(5'h05, 1, rd);
      chk(rd, 16'hFFFF);
      chk({15'h0, oe_seen}, 16'h0000);
      wr_reg(pbcs_pkg::REG_STAT, 16'h0000);
      rd_reg(pbcs_pkg::REG_STAT, 1, rd);
      chk(rd, 16'h796D);
      $display("test refusals done");
      set_stat(7'h72);
      set_stat(7'h62);
      n_rst = 0;
      wr_reg(pbcs_pkg::REG_CTRL, 16'h8000);
      repeat (24) @(posedge clk);
      chk(16'(n_rst), 16'(pbcs_pkg::SOFT_RST_CYCLES));
      rd_reg(pbcs_pkg::REG_CTRL, 1, rd);
      chk(rd, 16'h1140);
      rd_reg(pbcs_pkg::REG_STAT, 1, rd);
      chk(rd, 16'h796D);
      $display("test soft reset done");
      stop_test();
   end
endmodule : tb_pbcs_regs
